// file: rtl/input_route_pkg.sv
// constants for the input routing, sleep and limp-home control block
// assumes a single 200 MHz clock and an APB register port
package input_route_pkg;
    localparam int NUM_CH = 8;
    localparam logic [7:0] ROUTE_A_RESET = 8'h04;
    localparam logic [7:0] ROUTE_B_RESET = 8'h08;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [11:0] ADDR_ENABLE = 12'h000;
    localparam logic [11:0] ADDR_ROUTE_A = 12'h004;
    localparam logic [11:0] ADDR_ROUTE_B = 12'h008;
    localparam logic [11:0] ADDR_LEVEL = 12'h00C;
    localparam logic [11:0] ADDR_STATUS = 12'h010;
    localparam logic [11:0] ADDR_DRIVE = 12'h014;
    localparam int LVL_A_BIT = 0;
    localparam int LVL_B_BIT = 1;
    localparam int ST_MODE_LSB = 0;
    localparam int ST_BLOCK_BIT = 2;
    localparam int ST_UV_EN_BIT = 3;
    localparam int ST_WINDOW_BIT = 4;
    localparam int RESTART_NS = 1000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int RESTART_CYCLES = (RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {
        MODE_ACTIVE,
        MODE_SLEEP,
        MODE_LIMP
    } mode_t;
endpackage

// file: rtl/level_sync.sv
// two-flop synchroniser for one level
// assumes input changes slowly against the clock
module level_sync #(
    // reset value, the idle level of the pin, so no false change follows reset
    parameter logic INIT = 1'b0
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // data
    input wire logic d_in,
    output logic q_out
);
    logic stage;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage <= INIT;
            q_out <= INIT;
        end else begin
            stage <= d_in;
            q_out <= stage;
        end
    end
endmodule

// file: rtl/input_route_ctrl.sv
// control-pin logic of an eight-channel low-side switch: input routing, sleep, limp home
// assumes an APB master on the same clock; supply monitors arrive as level inputs
//
// Summary of operation
// - after reset input a drives channel 2, input b drives channel 3
// - two writable route tables attach any channels to each direct input
// - channel drive is enable bit OR any routed direct input that is high
// - input levels readable whenever the port is not blocked, including limp home
// - request low with an input high enters limp home, default channels follow their inputs
// - request low with both inputs low enters sleep
// - request low returns all registers to defaults
// - in sleep the undervoltage detectors are disabled
// - in sleep serial transfers are refused, data output stays off
// - both supplies low: stages off, serial blocked, registers reset
// - logic supply low: serial blocked, registers reset
// - in low-battery window an off channel is not switched on
// - in low-battery window on channels stay on until switched off
// - with request low, default channels follow inputs without logic supply
// - in limp home a tripped routed channel restarts after restart time
module input_route_ctrl
    import input_route_pkg::*;
#(
    parameter int RESTART_COUNT = RESTART_CYCLES
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // control pins
    input wire logic direct_input_a_in,
    input wire logic direct_input_b_in,
    input wire logic low_power_request_n_in,
    input wire logic chip_select_low_in,
    // supply monitors, high while the supply is below its level
    input wire logic battery_undervoltage_in,
    input wire logic logic_undervoltage_in,
    input wire logic battery_window_in,
    // per-channel trip from the protection logic
    input wire logic [NUM_CH-1:0] channel_trip_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // outputs
    output logic [NUM_CH-1:0] channel_drive_out,
    output logic serial_out_enable_out,
    output logic serial_blocked_out,
    output logic uv_detect_enable_out,
    output mode_t mode_out
);
    import input_route_pkg::*;

    localparam int CW = $clog2(RESTART_COUNT + 1);

    logic rst_meta, rst_n;
    logic in_a, in_b, req_n;
    logic [7:0] enable, route_a, route_b;
    logic [7:0] drive, next_drive, want, tripped;
    logic [CW-1:0] restart_cnt;
    mode_t mode, next_mode;
    logic reg_clear, blocked, apb_hit;

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // direct inputs and request pass through two flops before any decision
    level_sync #(.INIT(1'b0)) sync_a (.clk_in(sys_clk_in), .rst_n_in(rst_n),
        .d_in(direct_input_a_in), .q_out(in_a));
    level_sync #(.INIT(1'b0)) sync_b (.clk_in(sys_clk_in), .rst_n_in(rst_n),
        .d_in(direct_input_b_in), .q_out(in_b));
    // request starts at its idle high level, else a short false sleep follows reset
    level_sync #(.INIT(1'b1)) sync_req (.clk_in(sys_clk_in), .rst_n_in(rst_n),
        .d_in(low_power_request_n_in), .q_out(req_n));

    // the host keeps the request stable long enough; no filtering here
    always_comb begin
        if (req_n) begin
            next_mode = MODE_ACTIVE;
        end else if (in_a || in_b) begin
            next_mode = MODE_LIMP;
        end else begin
            next_mode = MODE_SLEEP;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            mode <= MODE_ACTIVE;
        end else begin
            mode <= next_mode;
        end
    end

    // request low or logic supply low resets the serial registers
    assign reg_clear = !req_n || logic_undervoltage_in;
    // sleep or logic undervoltage blocks the port
    assign blocked = (!req_n && !in_a && !in_b) || logic_undervoltage_in;
    assign apb_hit = psel_in && penable_in && !blocked;

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            enable <= ENABLE_RESET;
            route_a <= ROUTE_A_RESET;
            route_b <= ROUTE_B_RESET;
        end else if (reg_clear) begin
            enable <= ENABLE_RESET;
            route_a <= ROUTE_A_RESET;
            route_b <= ROUTE_B_RESET;
        end else if (apb_hit && pwrite_in) begin
            case (paddr_in)
                ADDR_ENABLE: begin
                    enable <= pwdata_in[7:0];
                end
                ADDR_ROUTE_A: begin
                    route_a <= pwdata_in[7:0];
                end
                ADDR_ROUTE_B: begin
                    route_b <= pwdata_in[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    // apb answers every access in its first access cycle; blocked reads return zero
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            prdata_out <= 32'h0000_0000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= psel_in && !penable_in;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
            if (psel_in && !penable_in) begin
                if (blocked) begin
                    pslverr_out <= 1'b1;
                end else begin
                    case (paddr_in)
                        ADDR_ENABLE: prdata_out <= {24'h000000, enable};
                        ADDR_ROUTE_A: prdata_out <= {24'h000000, route_a};
                        ADDR_ROUTE_B: prdata_out <= {24'h000000, route_b};
                        // input levels stay readable in limp home
                        ADDR_LEVEL: prdata_out <= {30'h0, in_b, in_a};
                        ADDR_STATUS: prdata_out <= {27'h0, battery_window_in,
                            uv_detect_enable_out, blocked, mode};
                        ADDR_DRIVE: prdata_out <= {24'h000000, drive};
                        default: pslverr_out <= 1'b1;
                    endcase
                end
            end
        end
    end

    // registers are at defaults in limp home, so routing gives default channels
    always_comb begin
        want = enable | (in_a ? route_a : 8'h00) | (in_b ? route_b : 8'h00);
        if (mode == MODE_LIMP || !req_n) begin
            // default channels follow inputs even without logic supply
            want = (in_a ? ROUTE_A_RESET : 8'h00) | (in_b ? ROUTE_B_RESET : 8'h00);
        end
        next_drive = want & ~tripped;
        if (battery_window_in) begin
            next_drive = next_drive & drive; // only keep or drop
        end
        if (battery_undervoltage_in && logic_undervoltage_in) begin
            next_drive = 8'h00;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            drive <= 8'h00;
        end else begin
            drive <= next_drive;
        end
    end

    // trip latches a channel off; in limp home it retries after the restart time
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            tripped <= 8'h00;
            restart_cnt <= '0;
        end else begin
            if (mode == MODE_LIMP && tripped != 8'h00) begin
                if (restart_cnt == CW'(RESTART_COUNT - 1)) begin
                    tripped <= channel_trip_in;
                    restart_cnt <= '0;
                end else begin
                    tripped <= tripped | channel_trip_in;
                    restart_cnt <= restart_cnt + 1'b1;
                end
            end else if (reg_clear && mode != MODE_LIMP) begin
                tripped <= channel_trip_in;
                restart_cnt <= '0;
            end else begin
                tripped <= tripped | channel_trip_in;
                restart_cnt <= '0;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            channel_drive_out <= 8'h00;
            serial_out_enable_out <= 1'b0;
            serial_blocked_out <= 1'b1;
            uv_detect_enable_out <= 1'b1;
            mode_out <= MODE_ACTIVE;
        end else begin
            channel_drive_out <= next_drive;
            serial_out_enable_out <= !chip_select_low_in && !blocked;
            serial_blocked_out <= blocked;
            uv_detect_enable_out <= !(!req_n && !in_a && !in_b);
            mode_out <= next_mode;
        end
    end
endmodule

// file: verif/input_route_sva.sv
// assertions on the pin-level behaviour of input_route_ctrl
// bound to the design by tb_top, sees only its ports
module input_route_sva
    import input_route_pkg::*;
(
    // clock, pins and supplies
    input wire logic sys_clk_in, reset_n_in, direct_input_a_in, direct_input_b_in,
    input wire logic low_power_request_n_in, battery_undervoltage_in,
    input wire logic logic_undervoltage_in, battery_window_in,
    input wire logic [NUM_CH-1:0] channel_trip_in,
    // outputs
    input wire logic [NUM_CH-1:0] channel_drive_out,
    input wire logic serial_out_enable_out, serial_blocked_out, uv_detect_enable_out,
    input wire mode_t mode_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    // eight calm cycles cover the pin synchronisers and, with the bench's RESTART_COUNT of 4, a pending restart
    sequence limp_req;
        (!low_power_request_n_in && (direct_input_a_in || direct_input_b_in)
            && channel_trip_in == 0) [*8];
    endsequence
    sequence sleep_req;
        (!low_power_request_n_in && !direct_input_a_in && !direct_input_b_in) [*8];
    endsequence
    chk_limp_entry: assert property (limp_req |=> mode_out == MODE_LIMP)
        else $error("limp mode missing");
    chk_limp_drive: assert property (limp_req |=>
        channel_drive_out == {4'h0, $past(direct_input_b_in), $past(direct_input_a_in), 2'h0})
        else $error("limp drive wrong");
    chk_sleep_entry: assert property (sleep_req |=>
        mode_out == MODE_SLEEP && channel_drive_out == 0) else $error("sleep missing");
    chk_sleep_serial: assert property (sleep_req |=>
        serial_blocked_out && !serial_out_enable_out) else $error("serial open in sleep");
    chk_sleep_uv_off: assert property (sleep_req |=> !uv_detect_enable_out)
        else $error("uv detect on in sleep");
    chk_vdd_block: assert property (logic_undervoltage_in [*3] |-> serial_blocked_out)
        else $error("serial open on low vdd");
    chk_both_uv_off: assert property (
        (battery_undervoltage_in && logic_undervoltage_in) [*3] |-> channel_drive_out == 0)
        else $error("stage on with supplies low");
    chk_window_hold: assert property (
        $past(battery_window_in, 2) && $past(battery_window_in)
        |-> (channel_drive_out & ~$past(channel_drive_out)) == 0)
        else $error("drive rose in window");
endmodule

// file: verif/host_pins.sv
// host model of the control pins: two direct inputs and the low-power request
// assumes set_pins is called just after a rising clock edge
module host_pins #(
    parameter int HOLD_CYCLES = 8
) (
    input wire logic clk_in,
    output logic direct_input_a_out, direct_input_b_out, low_power_request_n_out
);
    initial {direct_input_a_out, direct_input_b_out, low_power_request_n_out} = 3'h1;
    // pins move together, then stay put for the transition hold before anyone relies on them
    task automatic set_pins(input logic a, input logic b, input logic req_n);
        {direct_input_a_out, direct_input_b_out, low_power_request_n_out} <= {a, b, req_n};
        repeat (HOLD_CYCLES) @(posedge clk_in);
    endtask
endmodule

// file: verif/tb_top.sv
// bench for input_route_ctrl: apb registers, pin routing, sleep, limp home, supplies
// assumes host_pins and input_route_sva are compiled first
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import input_route_pkg::*;
    logic clk = '0, rst_n = '0, cs_n = '1, bat_uv = '0, vdd_uv = '0, win = '0;
    logic psel = '0, pen = '0, pwr = '0, rdy, serr, sl_err, sdo_en, uv_en, a, b, req_n;
    logic [11:0] addr = '0;
    logic [31:0] wdata = '0, prd, rdata;
    logic [7:0] trip = '0, drive;
    int err_count = 0;
    int n_compared = 0;
    input_route_ctrl #(.RESTART_COUNT(4)) dut_u (.sys_clk_in(clk), .reset_n_in(rst_n),
        .direct_input_a_in(a), .direct_input_b_in(b), .low_power_request_n_in(req_n),
        .chip_select_low_in(cs_n), .battery_undervoltage_in(bat_uv),
        .logic_undervoltage_in(vdd_uv), .battery_window_in(win), .channel_trip_in(trip),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(addr),
        .pwdata_in(wdata), .prdata_out(prd), .pready_out(rdy), .pslverr_out(serr),
        .channel_drive_out(drive), .serial_out_enable_out(sdo_en),
        .serial_blocked_out(), .uv_detect_enable_out(uv_en), .mode_out());
    host_pins host_u (.clk_in(clk), .direct_input_a_out(a), .direct_input_b_out(b),
        .low_power_request_n_out(req_n));
    initial forever #2.5 clk = ~clk;
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        final_report();
    end
    // answer is sampled at the rising edge; two idle edges let a stored write reach drive
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        int n = 0;
        {psel, pen, pwr, addr, wdata} <= {1'h1, 1'h0, w, ad, d};
        @(posedge clk);
        pen <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'h1 && n < 40);
        if (n >= 40) begin
            err_count++;
            $display("[FAIL] pready expected 1 seen %b", rdy);
        end
        rdata = prd;
        sl_err = serr;
        {psel, pen} <= 2'h0;
        repeat (2) @(posedge clk);
    endtask
    task automatic check(input string what, input logic [31:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [11:0] ad, input logic [31:0] exp, input logic e);
        apb('0, ad, '0);
        check($sformatf("read %h", ad), exp, rdata);
        check("pslverr", {31'h0, e}, {31'h0, sl_err});
    endtask
    function automatic logic [7:0] exp_drive(input logic [7:0] en, ra, rb, input logic ia, ib);
        return en | (ia ? ra : 8'h0) | (ib ? rb : 8'h0);
    endfunction
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        logic [7:0] en, ra, rb;
        void'($urandom(32'h3453));
        repeat (12) @(posedge clk);
        rst_n <= '1;
        repeat (4) @(posedge clk);
        rd(ADDR_ROUTE_A, {24'h0, ROUTE_A_RESET}, '0);
        rd(ADDR_ROUTE_B, {24'h0, ROUTE_B_RESET}, '0);
        rd(12'h020, '0, '1);
        for (int i = 0; i < 8; i++) begin
            {en, ra, rb} = (i == 0) ? 24'h00FFFF : 24'($urandom);
            apb('1, ADDR_ENABLE, {24'h0, en});
            apb('1, ADDR_ROUTE_A, {24'h0, ra});
            apb('1, ADDR_ROUTE_B, {24'h0, rb});
            host_u.set_pins(i[0], i[1], '1);
            check("drive", {24'h0, exp_drive(en, ra, rb, i[0], i[1])}, {24'h0, drive});
            rd(ADDR_LEVEL, {30'h0, i[1:0]}, '0);
        end
        host_u.set_pins('1, '0, '0);
        check("limp drive", 32'h4, {24'h0, drive});
        rd(ADDR_LEVEL, 32'h1, '0);
        trip <= 8'h04;
        @(posedge clk);
        trip <= 8'h00;
        for (int k = 0; k < 6 && drive[2] !== 1'h0; k++) @(posedge clk);
        check("tripped", '0, {24'h0, drive});
        repeat (12) @(posedge clk);
        check("restarted", 32'h4, {24'h0, drive});
        host_u.set_pins('0, '0, '1);
        rd(ADDR_ROUTE_A, {24'h0, ROUTE_A_RESET}, '0);
        host_u.set_pins('0, '0, '0);
        cs_n <= '0;
        rd(ADDR_LEVEL, '0, '1);
        check("sdo enable", '0, {31'h0, sdo_en});
        check("uv enable", '0, {31'h0, uv_en});
        cs_n <= '1;
        host_u.set_pins('0, '0, '1);
        apb('1, ADDR_ENABLE, 32'hFF);
        {bat_uv, vdd_uv} <= 2'h3;
        repeat (4) @(posedge clk);
        check("uv drive", '0, {24'h0, drive});
        bat_uv <= '0;
        rd(ADDR_ENABLE, '0, '1);
        vdd_uv <= '0;
        rd(ADDR_ENABLE, '0, '0);
        apb('1, ADDR_ENABLE, 32'h1);
        win <= '1;
        apb('1, ADDR_ENABLE, 32'h3);
        check("window hold", 32'h1, {24'h0, drive});
        apb('1, ADDR_ENABLE, 32'h0);
        check("window drop", '0, {24'h0, drive});
        final_report();
    end
endmodule
bind input_route_ctrl input_route_sva sva_u (.sys_clk_in, .reset_n_in, .direct_input_a_in,
    .direct_input_b_in, .low_power_request_n_in, .battery_undervoltage_in,
    .logic_undervoltage_in, .battery_window_in, .channel_trip_in, .channel_drive_out,
    .serial_out_enable_out, .serial_blocked_out, .uv_detect_enable_out, .mode_out);
